// >>> core/mei_defs.svh
// Offsets, field positions, reset values and threshold figures of the motion event block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef MEI_DEFS_SVH
`define MEI_DEFS_SVH

// ==========================================================================
// Widths, register count and reset value
`define MEI_AW 5
`define MEI_DW 24
`define MEI_NREG 18
`define MEI_REG_RST 8'h00

// ==========================================================================
// Register offsets
`define MEI_HG_READY_ROUTE 5'h00
`define MEI_HG_FUNC_EN 5'h01
`define MEI_INACT_SHOCK 5'h02
`define MEI_PIN_A_ROUTE 5'h03
`define MEI_PIN_B_ROUTE 5'h04
`define MEI_FILTER_CFG 5'h05
`define MEI_BASIC_CTRL 5'h06
`define MEI_FALL_CFG 5'h07
`define MEI_WAKE_DURATION_COUNT 5'h08
`define MEI_WAKE_THR 5'h09
`define MEI_IDLE_DUR 5'h0a
`define MEI_X_OFS 5'h0b
`define MEI_Y_OFS 5'h0c
`define MEI_Z_OFS 5'h0d
`define MEI_WAKE_SRC 5'h0e
`define MEI_GLOBAL_SRC 5'h0f
`define MEI_HG_WAKE_SRC 5'h10
`define MEI_IF_CFG 5'h11

// ==========================================================================
// Field positions
`define MEI_B_HG_RDY_A 7
`define MEI_B_HG_RDY_B 6
`define MEI_B_HG_ON 7
`define MEI_B_HG_KIND 6
`define MEI_B_HG_WAKE_B 5
`define MEI_B_HG_WAKE_A 4
`define MEI_B_HG_IMP_B 7
`define MEI_B_HG_IMP_A 6
`define MEI_B_WAKE_PIN 5
`define MEI_B_FALL_PIN 4
`define MEI_B_FILT_SEL 4
`define MEI_B_LATCH 0
`define MEI_B_BASIC_ON 7
`define MEI_B_FALL_DUR5 7
`define MEI_B_USR_OFS 6
`define MEI_B_POL_LOW 0

// ==========================================================================
// Threshold figures in units of 1/64 mg, and the largest wake weight shift
`define MEI_FF_THR_0 24'd9984
`define MEI_FF_THR_1 24'd14016
`define MEI_FF_THR_2 24'd16000
`define MEI_FF_THR_3 24'd19968
`define MEI_FF_THR_4 24'd22016
`define MEI_FF_THR_5 24'd25984
`define MEI_FF_THR_6 24'd30016
`define MEI_FF_THR_7 24'd32000
`define MEI_WAKE_LSB 24'd500
`define MEI_WAKE_W_MAX 3'h5

`endif

// >>> core/mei_pkg.sv
// Types shared by the motion event block.
// Assumes mei_defs.svh is reachable by bare name.
`include "mei_defs.svh"

package mei_pkg;

  typedef logic signed [`MEI_DW-1:0] mei_smp_t;

  typedef struct packed {
    mei_smp_t x;
    mei_smp_t y;
    mei_smp_t z;
  } mei_xyz_t;

  typedef struct packed {
    logic drdy;
    logic wake_lvl;
    logic wake_chg;
    logic shock;
  } mei_hg_t;

  typedef struct packed {
    logic [`MEI_AW-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mei_bus_t;

  typedef struct packed {
    logic [`MEI_NREG-1:0][7:0] regs;
    mei_xyz_t prev;
    logic [5:0] ff_cnt;
    logic [1:0] wu_cnt;
    logic ff_flag;
    logic wu_flag;
    logic [2:0] wu_axes;
    logic pin_a;
    logic pin_b;
    logic gen_on;
    logic [7:0] rdata;
  } mei_state_t;

endpackage

// >>> core/mei_top.sv
// Motion event interrupt logic: high-g routing, free-fall and wake-up detection, two event pins.
// Assumes samples arrive with a one-cycle strobe, in signed units of 1/64 mg, synchronous to MCLK.
//
// Local design decisions: the placing of the registers and strobed register access.
`include "mei_defs.svh"

// Overview of operation
// R1 - High-g data-ready goes to pin A by bit 7, pin B by bit 6.
// R2 - High-g routing bits reset to zero; writing one connects the signal.
// R3 - High-g wake and shock generation runs only while its enable bit is set.
// R4 - High-g function bit 6 selects which high-g wake kind reaches the pins.
// R5 - High-g wake goes to pin B by bit 5, pin A by bit 4.
// R6 - Idle threshold register bits 7 and 6 route high-g impact to the pins.
// R7 - Global source shows OR of high-g wake and high-g impact events.
// R8 - Free-fall needs all three axes inside the zone for the programmed duration.
// R9 - Free-fall needs basic enable, reaches pins by own routing bits, readable in both sources.
// R10 - Without latching, free-fall clears when its condition stops holding.
// R11 - Latched routed free-fall holds until wake source or global source read.
// R12 - Latching acts only while the event is routed to a pin.
// R13 - Free-fall threshold code maps to 156 up to 500 mg, any full scale.
// R14 - Free-fall duration is six bits split over two registers, in sample periods.
// R15 - Wake uses slope filter when select is zero, high-pass when one.
// R16 - Select and user-offset bits set: low-pass data plus offsets is compared.
// R17 - Wake threshold LSB weight 7.8125 to 125 mg, 250 mg for codes above.
// R18 - Wake compares absolute axis values, strictly greater than threshold.
// R19 - Wake rises once consecutive over-threshold samples exceed the duration field.
// R20 - Wake needs basic enable, routing only to reach pins; flags show event and causing axes.
// R21 - Without latching, wake clears once data drop below threshold.
// R22 - Latched routed wake holds pin and axis flags until a source read.
// R23 - Host reads wake source, not global, to get axis flags.
// R24 - Several signals routed to one pin are ORed.
// R25 - Polarity bit zero gives active-high pins, one active-low.
// R26 - Detectors evaluate once per fresh low-g sample.
module mei_top (
  // Clock, reset and enable
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // Register port
  input wire mei_pkg::mei_bus_t BUS,
  output logic [7:0] RDATA,
  // Low-g samples
  input wire logic SMP_STB,
  input wire mei_pkg::mei_xyz_t SMP_LP,
  input wire mei_pkg::mei_xyz_t SMP_HP,
  // High-g events
  input wire mei_pkg::mei_hg_t HG_EVT,
  output logic HG_GEN_ON,
  // Event pins
  output logic EVT_PIN_A,
  output logic EVT_PIN_B
);

  // ==========================================================================
  // Helpers
  function automatic mei_pkg::mei_smp_t abs_of(input mei_pkg::mei_smp_t v);
    abs_of = v[`MEI_DW-1] ? -v : v;
  endfunction

  function automatic logic [`MEI_DW-1:0] fall_thr(input logic [2:0] code);
    unique case (code)
      3'h0: fall_thr = `MEI_FF_THR_0;
      3'h1: fall_thr = `MEI_FF_THR_1;
      3'h2: fall_thr = `MEI_FF_THR_2;
      3'h3: fall_thr = `MEI_FF_THR_3;
      3'h4: fall_thr = `MEI_FF_THR_4;
      3'h5: fall_thr = `MEI_FF_THR_5;
      3'h6: fall_thr = `MEI_FF_THR_6;
      3'h7: fall_thr = `MEI_FF_THR_7;
    endcase
  endfunction

  function automatic logic is_src_read(input mei_pkg::mei_bus_t b);
    is_src_read = b.rd && (b.addr == `MEI_WAKE_SRC || b.addr == `MEI_GLOBAL_SRC);
  endfunction

  // ==========================================================================
  // State
  mei_pkg::mei_state_t s_ff;
  mei_pkg::mei_state_t nxt_s;

  logic [7:0] hg_rdy_reg;
  logic [7:0] hg_fn_reg;
  logic [7:0] shock_reg;
  logic [7:0] route_a_reg;
  logic [7:0] route_b_reg;
  logic [7:0] filt_reg;
  logic [7:0] wdur_reg;
  logic [7:0] wthr_reg;
  logic basic_on;
  logic pol_low;
  logic hg_wake_sel;
  logic hg_any;
  logic fall_routed;
  logic wake_routed;
  logic fall_latched;
  logic wake_latched;
  logic src_read;
  logic [5:0] fall_n;
  logic [`MEI_DW-1:0] ff_thr;
  logic [`MEI_DW-1:0] wu_thr;
  logic [2:0] wu_w;
  logic [2:0] axis_in;
  logic [2:0] axis_over;
  logic all_in;
  logic any_over;
  logic [5:0] ff_cnt_nxt;
  logic [1:0] wu_cnt_nxt;
  logic fall_cond;
  logic wake_cond;
  logic act_a;
  logic act_b;
  logic [7:0] rd_val;

  assign hg_rdy_reg = s_ff.regs[`MEI_HG_READY_ROUTE];
  assign hg_fn_reg = s_ff.regs[`MEI_HG_FUNC_EN];
  assign shock_reg = s_ff.regs[`MEI_INACT_SHOCK];
  assign route_a_reg = s_ff.regs[`MEI_PIN_A_ROUTE];
  assign route_b_reg = s_ff.regs[`MEI_PIN_B_ROUTE];
  assign filt_reg = s_ff.regs[`MEI_FILTER_CFG];
  assign wdur_reg = s_ff.regs[`MEI_WAKE_DURATION_COUNT];
  assign wthr_reg = s_ff.regs[`MEI_WAKE_THR];
  assign basic_on = s_ff.regs[`MEI_BASIC_CTRL][`MEI_B_BASIC_ON];
  assign pol_low = s_ff.regs[`MEI_IF_CFG][`MEI_B_POL_LOW];
  assign src_read = is_src_read(BUS);

  // ==========================================================================
  // High-g routing
  assign hg_wake_sel = s_ff.gen_on && (hg_fn_reg[`MEI_B_HG_KIND] ? HG_EVT.wake_chg : HG_EVT.wake_lvl); // R4 R3
  assign hg_any = s_ff.gen_on && (HG_EVT.wake_lvl || HG_EVT.shock); // R7

  // ==========================================================================
  // Thresholds and filter choice
  assign fall_n = {wdur_reg[`MEI_B_FALL_DUR5], s_ff.regs[`MEI_FALL_CFG][7:3]}; // R14
  assign ff_thr = fall_thr(s_ff.regs[`MEI_FALL_CFG][2:0]); // R13
  assign wu_w = (s_ff.regs[`MEI_IDLE_DUR][6:4] > `MEI_WAKE_W_MAX) ? `MEI_WAKE_W_MAX
                : s_ff.regs[`MEI_IDLE_DUR][6:4];
  assign wu_thr = (`MEI_DW'(wthr_reg[5:0]) * `MEI_WAKE_LSB) << wu_w; // R17

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_axis
      mei_pkg::mei_smp_t lp_v;
      mei_pkg::mei_smp_t hp_v;
      mei_pkg::mei_smp_t pv_v;
      mei_pkg::mei_smp_t ofs_v;
      mei_pkg::mei_smp_t slope_v;
      mei_pkg::mei_smp_t lpo_v;
      mei_pkg::mei_smp_t wk_v;
      assign lp_v = (ax == 0) ? SMP_LP.x : (ax == 1) ? SMP_LP.y : SMP_LP.z;
      assign hp_v = (ax == 0) ? SMP_HP.x : (ax == 1) ? SMP_HP.y : SMP_HP.z;
      assign pv_v = (ax == 0) ? s_ff.prev.x : (ax == 1) ? s_ff.prev.y : s_ff.prev.z;
      assign ofs_v = `MEI_DW'(signed'(s_ff.regs[`MEI_X_OFS + ax])) * signed'(`MEI_WAKE_LSB);
      assign slope_v = (lp_v - pv_v) >>> 1;
      assign lpo_v = lp_v + ofs_v;
      assign wk_v = !filt_reg[`MEI_B_FILT_SEL] ? slope_v
                    : wthr_reg[`MEI_B_USR_OFS] ? lpo_v : hp_v; // R15 R16
      assign axis_in[ax] = abs_of(lp_v) < ff_thr; // R8
      assign axis_over[ax] = abs_of(wk_v) > wu_thr; // R18
    end
  endgenerate

  assign all_in = &axis_in;
  assign any_over = |axis_over;

  // ==========================================================================
  // Duration counting, once per fresh sample
  assign ff_cnt_nxt = !all_in ? 6'h00 : (s_ff.ff_cnt == 6'h3f) ? s_ff.ff_cnt : s_ff.ff_cnt + 6'h01; // R26
  assign wu_cnt_nxt = !any_over ? 2'h0 : (s_ff.wu_cnt == 2'h3) ? s_ff.wu_cnt : s_ff.wu_cnt + 2'h1;
  assign fall_cond = all_in && (ff_cnt_nxt >= fall_n); // R8 R14
  assign wake_cond = any_over && ({1'b0, s_ff.wu_cnt} + 3'h1 > {1'b0, wdur_reg[6:5]}); // R19

  assign fall_routed = route_a_reg[`MEI_B_FALL_PIN] || route_b_reg[`MEI_B_FALL_PIN];
  assign wake_routed = route_a_reg[`MEI_B_WAKE_PIN] || route_b_reg[`MEI_B_WAKE_PIN];
  assign fall_latched = filt_reg[`MEI_B_LATCH] && fall_routed; // R12
  assign wake_latched = filt_reg[`MEI_B_LATCH] && wake_routed; // R12

  // ==========================================================================
  // Pin terms
  assign act_a = (HG_EVT.drdy && hg_rdy_reg[`MEI_B_HG_RDY_A])
               || (hg_wake_sel && hg_fn_reg[`MEI_B_HG_WAKE_A])
               || (s_ff.gen_on && HG_EVT.shock && shock_reg[`MEI_B_HG_IMP_A])
               || (s_ff.ff_flag && route_a_reg[`MEI_B_FALL_PIN])
               || (s_ff.wu_flag && route_a_reg[`MEI_B_WAKE_PIN]); // R1 R5 R6 R9 R20 R24
  assign act_b = (HG_EVT.drdy && hg_rdy_reg[`MEI_B_HG_RDY_B])
               || (hg_wake_sel && hg_fn_reg[`MEI_B_HG_WAKE_B])
               || (s_ff.gen_on && HG_EVT.shock && shock_reg[`MEI_B_HG_IMP_B])
               || (s_ff.ff_flag && route_b_reg[`MEI_B_FALL_PIN])
               || (s_ff.wu_flag && route_b_reg[`MEI_B_WAKE_PIN]); // R1 R5 R6 R9 R20 R24

  // ==========================================================================
  // Read mux
  always_comb begin
    rd_val = 8'h00;
    if (BUS.addr < `MEI_AW'(`MEI_NREG)) begin
      rd_val = s_ff.regs[BUS.addr];
    end
    unique case (BUS.addr)
      `MEI_WAKE_SRC: rd_val = {2'h0, s_ff.ff_flag, 1'b0, s_ff.wu_flag, s_ff.wu_axes}; // R9 R20
      `MEI_GLOBAL_SRC: rd_val = {5'h00, hg_any, s_ff.wu_flag, s_ff.ff_flag}; // R7 R9
      `MEI_HG_WAKE_SRC: rd_val = {6'h00, s_ff.gen_on && HG_EVT.wake_lvl, s_ff.gen_on && HG_EVT.shock};
      default: rd_val = rd_val;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    if (CE) begin
      nxt_s.rdata = BUS.rd ? rd_val : 8'h00;
      if (BUS.wr && BUS.addr < `MEI_WAKE_SRC) begin
        nxt_s.regs[BUS.addr] = BUS.wdata; // R2
      end else if (BUS.wr && BUS.addr == `MEI_IF_CFG) begin
        nxt_s.regs[BUS.addr] = BUS.wdata;
      end
      nxt_s.gen_on = hg_fn_reg[`MEI_B_HG_ON]; // R3
      if (src_read) begin
        if (fall_latched) begin
          nxt_s.ff_flag = 1'b0; // R11
        end
        if (wake_latched) begin
          nxt_s.wu_flag = 1'b0; // R22
          nxt_s.wu_axes = 3'h0;
        end
      end
      if (!basic_on) begin
        nxt_s.ff_cnt = 6'h00; // R9
        nxt_s.wu_cnt = 2'h0;
        nxt_s.ff_flag = 1'b0;
        nxt_s.wu_flag = 1'b0;
        nxt_s.wu_axes = 3'h0;
      end else if (SMP_STB) begin
        nxt_s.prev = SMP_LP; // R26
        nxt_s.ff_cnt = ff_cnt_nxt;
        nxt_s.wu_cnt = wu_cnt_nxt;
        if (fall_latched) begin
          nxt_s.ff_flag = nxt_s.ff_flag || fall_cond; // R11
        end else begin
          nxt_s.ff_flag = fall_cond; // R10
        end
        if (!wake_latched) begin
          nxt_s.wu_flag = wake_cond; // R21
          nxt_s.wu_axes = wake_cond ? axis_over : 3'h0;
        end else if (wake_cond && !s_ff.wu_flag) begin
          nxt_s.wu_flag = 1'b1; // R22
          nxt_s.wu_axes = axis_over;
        end else if (wake_cond && src_read) begin
          nxt_s.wu_flag = 1'b1;
          nxt_s.wu_axes = axis_over;
        end
      end
      nxt_s.pin_a = act_a ^ pol_low; // R25
      nxt_s.pin_b = act_b ^ pol_low; // R25
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign RDATA = s_ff.rdata;
  assign HG_GEN_ON = s_ff.gen_on;
  assign EVT_PIN_A = s_ff.pin_a;
  assign EVT_PIN_B = s_ff.pin_b;

  // ==========================================================================
  // Checks
  chk_hg_ready_route: assert property (@(posedge MCLK) disable iff (!RST_N) // R1
    CE && HG_EVT.drdy && hg_rdy_reg[`MEI_B_HG_RDY_A] |=> EVT_PIN_A == !$past(pol_low))
    else $error("high-g data-ready not on pin A");

  chk_route_write: assert property (@(posedge MCLK) disable iff (!RST_N) // R2
    CE && BUS.wr && BUS.addr == `MEI_INACT_SHOCK |=> shock_reg == $past(BUS.wdata))
    else $error("routing write not stored");

  chk_hg_gate: assert property (@(posedge MCLK) disable iff (!RST_N) // R3
    CE && !hg_fn_reg[`MEI_B_HG_ON] |=> !HG_GEN_ON ##0 !hg_any)
    else $error("high-g generator active while disabled");

  chk_hg_summary: assert property (@(posedge MCLK) disable iff (!RST_N) // R7
    CE && BUS.rd && BUS.addr == `MEI_GLOBAL_SRC |=> RDATA[2] == $past(hg_any))
    else $error("high-g summary flag wrong");

  chk_fall_auto_clear: assert property (@(posedge MCLK) disable iff (!RST_N) // R10
    CE && basic_on && SMP_STB && !all_in && !fall_latched |=> !s_ff.ff_flag)
    else $error("free-fall flag kept without latching");

  chk_fall_hold: assert property (@(posedge MCLK) disable iff (!RST_N) // R11
    CE && basic_on && s_ff.ff_flag && fall_latched && !src_read |=> s_ff.ff_flag [*1])
    else $error("latched free-fall lost before read");

  chk_wake_count: assert property (@(posedge MCLK) disable iff (!RST_N) // R19
    // The run counter saturates at three, so a duration of three is met while it stands there.
    $rose(s_ff.wu_flag) |-> $past(any_over)
      && ($past(wu_cnt_nxt) > $past(wdur_reg[6:5]) || $past(wu_cnt_nxt) == 2'h3))
    else $error("wake raised before duration");

  chk_pin_polarity: assert property (@(posedge MCLK) disable iff (!RST_N) // R25
    CE && !act_b |=> EVT_PIN_B == $past(pol_low))
    else $error("idle pin B level wrong");

  chk_pin_or: assert property (@(posedge MCLK) disable iff (!RST_N) // R24
    CE && s_ff.wu_flag && route_a_reg[`MEI_B_WAKE_PIN] && HG_EVT.drdy |=> EVT_PIN_A != $past(pol_low))
    else $error("pin A not the OR of its sources");

  chk_hg_kind: assert property (@(posedge MCLK) disable iff (!RST_N) // R4
    CE && s_ff.gen_on && hg_fn_reg[`MEI_B_HG_KIND] && hg_fn_reg[`MEI_B_HG_WAKE_A] && HG_EVT.wake_chg
    |=> EVT_PIN_A == !$past(pol_low))
    else $error("selected high-g wake kind not on pin A");

  chk_hg_wake_route: assert property (@(posedge MCLK) disable iff (!RST_N) // R5
    CE && hg_wake_sel && hg_fn_reg[`MEI_B_HG_WAKE_B] |=> EVT_PIN_B == !$past(pol_low))
    else $error("high-g wake not on pin B");

  chk_hg_impact_route: assert property (@(posedge MCLK) disable iff (!RST_N) // R6
    CE && s_ff.gen_on && HG_EVT.shock && shock_reg[`MEI_B_HG_IMP_A] |=> EVT_PIN_A == !$past(pol_low))
    else $error("high-g impact not on pin A");

  chk_basic_gate: assert property (@(posedge MCLK) disable iff (!RST_N) // R9
    CE && !basic_on |=> !s_ff.ff_flag && !s_ff.wu_flag && s_ff.ff_cnt == 6'h00)
    else $error("event flags set while basic enable is off");

  chk_fall_duration: assert property (@(posedge MCLK) disable iff (!RST_N) // R8
    $rose(s_ff.ff_flag) |-> $past(all_in) && $past(ff_cnt_nxt) >= $past(fall_n))
    else $error("free-fall raised before duration");

  chk_unlatched_read: assert property (@(posedge MCLK) disable iff (!RST_N) // R12
    CE && basic_on && !SMP_STB && src_read && !wake_latched |=> s_ff.wu_flag == $past(s_ff.wu_flag))
    else $error("source read cleared an unlatched wake flag");

  chk_axis_flags: assert property (@(posedge MCLK) disable iff (!RST_N) // R20
    $rose(s_ff.wu_flag) |-> s_ff.wu_axes != 3'h0)
    else $error("wake raised with no axis flag");

  chk_wake_auto_clear: assert property (@(posedge MCLK) disable iff (!RST_N) // R21
    CE && basic_on && SMP_STB && !any_over && !wake_latched |=> !s_ff.wu_flag)
    else $error("wake flag kept without latching");

  chk_wake_hold: assert property (@(posedge MCLK) disable iff (!RST_N) // R22
    CE && basic_on && s_ff.wu_flag && wake_latched && !src_read
    |=> s_ff.wu_flag && s_ff.wu_axes == $past(s_ff.wu_axes))
    else $error("latched wake lost before read");

  chk_sample_only: assert property (@(posedge MCLK) disable iff (!RST_N) // R26
    CE && basic_on && !SMP_STB |=> $stable(s_ff.ff_cnt) && $stable(s_ff.wu_cnt))
    else $error("duration counter moved without a sample");

endmodule

// >>> testbench/mei_host_mdl.sv
// Host-side watcher of the two event pins.
// Assumes the bench passes in the pin polarity it has programmed.
module mei_host_mdl (
  // Event pins
  input wire logic pin_a,
  input wire logic pin_b,
  // Host view
  input wire logic pol_low,
  output logic act_a,
  output logic act_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Pin levels
  // The host reads an asserted pin as active whatever the programmed polarity.
  assign act_a = pin_a ^ pol_low;
  assign act_b = pin_b ^ pol_low;
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the motion event block: register tasks, sample and high-g stimulus.
// Assumes the core package and header are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, stb, pol, act_a, act_b, gen_on, pin_a, pin_b;
  logic [7:0] rdata;
  mei_pkg::mei_bus_t bus;
  mei_pkg::mei_xyz_t lp, hp, z0, lp0, hx;
  mei_pkg::mei_hg_t hg;
  int miscompares, check_count, t;
  int fth[8] = '{9984, 14016, 16000, 19968, 22016, 25984, 30016, 32000};

  mei_top mei_top_i (.MCLK(clk), .RST_N(rst_n), .CE(ce), .BUS(bus), .RDATA(rdata), .SMP_STB(stb),
    .SMP_LP(lp), .SMP_HP(hp), .HG_EVT(hg), .HG_GEN_ON(gen_on), .EVT_PIN_A(pin_a), .EVT_PIN_B(pin_b));
  mei_host_mdl mei_host_mdl_i (.pin_a(pin_a), .pin_b(pin_b), .pol_low(pol), .act_a(act_a), .act_b(act_b));

  // ==========================================================================
  // Helpers
  function automatic mei_pkg::mei_xyz_t v(input int a, input int b, input int c);
    return {24'(a), 24'(b), 24'(c)};
  endfunction
  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t ns: expected %h, got %h", $time, e, g);
    end
  endtask
  task automatic cmp2(input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t ns: expected %h, got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 cmp8(e, rdata);
    @(posedge clk);
  endtask
  task automatic smp(input mei_pkg::mei_xyz_t l, input mei_pkg::mei_xyz_t h);
    lp <= l;
    hp <= h;
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic hgs(input logic [3:0] e);
    hg <= e;
    repeat (2) @(posedge clk);
  endtask
  task automatic pins(input logic [1:0] e);
    #1 cmp2(e, {act_a, act_b});
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    stb = 1'b0;
    pol = 1'b0;
    bus = '0;
    lp = '0;
    hp = '0;
    hg = '0;
    z0 = '0;
    lp0 = v(0, 0, 30000);
    hx = v(4001, 0, 0);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(5'h00, 8'h00);
    rdc(5'h01, 8'h00);
    rdc(5'h02, 8'h00);
    rdc(5'h05, 8'h00);
    rdc(5'h1f, 8'h00);
    wr(5'h0e, 8'hff);
    rdc(5'h0e, 8'h00);
    wr(5'h00, 8'h80);
    hgs(4'h8);
    pins(2'b10);
    wr(5'h00, 8'h40);
    pins(2'b01);
    wr(5'h00, 8'h00);
    pins(2'b00);
    hgs(4'h4);
    wr(5'h01, 8'h10);
    pins(2'b00);
    rdc(5'h10, 8'h00);
    #1 cmp2(2'b00, {1'b0, gen_on});
    @(posedge clk);
    wr(5'h01, 8'h90);
    @(posedge clk);
    pins(2'b10);
    rdc(5'h10, 8'h02);
    #1 cmp2(2'b01, {1'b0, gen_on});
    @(posedge clk);
    wr(5'h01, 8'hd0);
    pins(2'b00);
    hgs(4'h2);
    pins(2'b10);
    hgs(4'h4);
    wr(5'h01, 8'ha0);
    pins(2'b01);
    hgs(4'h1);
    wr(5'h01, 8'h80);
    wr(5'h02, 8'h40);
    pins(2'b10);
    wr(5'h02, 8'h80);
    pins(2'b01);
    rdc(5'h0f, 8'h04);
    rdc(5'h10, 8'h01);
    wr(5'h02, 8'h40);
    wr(5'h00, 8'h80);
    hgs(4'h9);
    pins(2'b10);
    hgs(4'h8);
    pins(2'b10);
    pol <= 1'b1;
    wr(5'h11, 8'h01);
    pins(2'b10);
    hgs(4'h0);
    pins(2'b00);
    #1 cmp2(2'b11, {pin_a, pin_b});
    @(posedge clk);
    pol <= 1'b0;
    wr(5'h11, 8'h00);
    wr(5'h00, 8'h00);
    wr(5'h01, 8'h00);
    wr(5'h02, 8'h00);
    // Free-fall with the wake threshold parked out of reach.
    wr(5'h06, 8'h80);
    wr(5'h09, 8'h3f);
    wr(5'h0a, 8'h50);
    wr(5'h03, 8'h10);
    wr(5'h07, 8'h13);
    smp(v(19967, -19967, 0), z0);
    rdc(5'h0e, 8'h00);
    repeat (2) smp(v(19967, -19967, 0), z0);
    rdc(5'h0e, 8'h20);
    rdc(5'h0f, 8'h01);
    pins(2'b10);
    wr(5'h04, 8'h10);
    pins(2'b11);
    wr(5'h04, 8'h00);
    smp(v(19968, 0, 0), z0);
    rdc(5'h0e, 8'h00);
    pins(2'b00);
    wr(5'h05, 8'h01);
    repeat (3) smp(v(0, 0, -19967), z0);
    smp(v(19968, 0, 0), z0);
    pins(2'b10);
    rdc(5'h0e, 8'h20);
    pins(2'b00);
    repeat (3) smp(v(0, 0, 0), z0);
    smp(v(19968, 0, 0), z0);
    rdc(5'h0f, 8'h01);
    pins(2'b00);
    wr(5'h03, 8'h00);
    repeat (3) smp(v(0, 0, 0), z0);
    smp(v(19968, 0, 0), z0);
    rdc(5'h0e, 8'h00);
    wr(5'h08, 8'h80);
    repeat (3) smp(v(0, 0, 0), z0);
    rdc(5'h0e, 8'h00);
    wr(5'h08, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(5'h07, 8'(c));
      smp(v(fth[c] - 1, 0, 0), z0);
      rdc(5'h0e, 8'h20);
      smp(v(fth[c], 0, 0), z0);
      rdc(5'h0e, 8'h00);
    end
    // Wake-up on the high-pass, slope and low-pass-plus-offset paths, free-fall held off by the z axis.
    wr(5'h07, 8'h00);
    wr(5'h05, 8'h10);
    wr(5'h03, 8'h20);
    wr(5'h09, 8'h01);
    for (int c = 0; c < 8; c++) begin
      t = 500 << (c > 5 ? 5 : c);
      wr(5'h0a, 8'(c << 4));
      smp(lp0, v(0, -t, 0));
      rdc(5'h0e, 8'h00);
      smp(lp0, v(0, -(t + 1), 0));
      rdc(5'h0e, 8'h0a);
    end
    pins(2'b10);
    wr(5'h0a, 8'h30);
    smp(lp0, z0);
    rdc(5'h0e, 8'h00);
    pins(2'b00);
    hp <= hx;
    repeat (3) @(posedge clk);
    rdc(5'h0e, 8'h00);
    wr(5'h08, 8'h20);
    smp(lp0, hx);
    rdc(5'h0e, 8'h00);
    smp(lp0, hx);
    rdc(5'h0e, 8'h09);
    wr(5'h08, 8'h00);
    wr(5'h05, 8'h00);
    smp(lp0, z0);
    smp(v(8002, 0, 30000), z0);
    rdc(5'h0e, 8'h09);
    smp(v(8002, 0, 30000), hx);
    rdc(5'h0e, 8'h00);
    wr(5'h05, 8'h10);
    wr(5'h09, 8'h41);
    wr(5'h0b, 8'h08);
    wr(5'h0d, 8'hc4);
    smp(v(1, 0, 30000), z0);
    rdc(5'h0e, 8'h09);
    smp(v(0, 0, 30000), z0);
    rdc(5'h0e, 8'h00);
    wr(5'h09, 8'h01);
    wr(5'h05, 8'h11);
    smp(lp0, v(0, 0, 4001));
    smp(lp0, hx);
    smp(lp0, z0);
    hgs(4'h8);
    pins(2'b10);
    rdc(5'h0e, 8'h0c);
    pins(2'b00);
    smp(lp0, v(0, 0, 4001));
    smp(lp0, z0);
    rdc(5'h0f, 8'h02);
    rdc(5'h0e, 8'h00);
    wr(5'h06, 8'h00);
    smp(lp0, hx);
    rdc(5'h0e, 8'h00);
    end_sim();
  end
endmodule
